// ### sync_serial_pkg.sv
// Package with register map, field positions, reset values and synchroniser depth for the synchronous serial port
package sync_serial_pkg;

  localparam logic [11:0] TX_CTRL_OFS   = 12'h000;
  localparam logic [11:0] TX_BUF_OFS    = 12'h004;
  localparam logic [11:0] RX_CTRL_OFS   = 12'h008;
  localparam logic [11:0] RX_DATA_OFS   = 12'h00c;
  localparam logic [11:0] RATE_CTRL_OFS = 12'h010;
  localparam logic [11:0] DIV_HIGH_OFS  = 12'h014;
  localparam logic [11:0] DIV_LOW_OFS   = 12'h018;
  localparam logic [11:0] IRQ_OFS       = 12'h01c;

  // Transmit control fields
  localparam int TXC_CLK_SRC  = 7;
  localparam int TXC_NINE     = 6;
  localparam int TXC_EN       = 5;
  localparam int TXC_SYNC     = 4;
  localparam int TXC_EMPTY    = 1;
  localparam int TXC_NINTH    = 0;
  // Receive control fields
  localparam int RXC_PORT_EN  = 7;
  localparam int RXC_NINE     = 6;
  localparam int RXC_SINGLE   = 5;
  localparam int RXC_CONT     = 4;
  localparam int RXC_OVERRUN  = 1;
  localparam int RXC_NINTH    = 0;
  // Rate control fields
  localparam int RATE_POL     = 4;
  localparam int RATE_WIDE    = 3;
  // Interrupt register fields
  localparam int IRQ_TX_FLAG  = 0;
  localparam int IRQ_RX_FLAG  = 1;
  localparam int IRQ_TX_EN    = 2;
  localparam int IRQ_RX_EN    = 3;

  localparam logic [7:0] TX_CTRL_RST   = 8'h02;
  localparam logic [7:0] RX_CTRL_RST   = 8'h00;
  localparam logic [7:0] RATE_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST       = 8'h00;

  // Data input synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage : sync_serial_pkg

// ### sync_master_serial_txrx.sv
// Synchronous master serial transmitter and receiver with APB register access
// Notes on behaviour
// [R1] Load shifter only after previous last bit
// [R2] Holding-to-shifter move in one cycle, flag set
// [R3] Empty flag unclearable by software; write clears
// [R4] Read-only shifter empty status, bit one
// [R5] Shifter not visible in register map
// [R6] Software sets sync, enable, clock source together
// [R7] Nine-bit option shifts ninth bit out
// [R8] Write to holding buffer starts transmission
// [R9] Software programs divisor before enabling port
// [R10] Single or continuous enable starts reception
// [R11] Sample data on falling shift clock edge; code samples on the rising edge when the polarity bit is set
// [R12] Single gives one word; continuous repeats
// [R13] Continuous enable wins when both set
// [R14] Receive flag set; interrupt only if enabled
// [R15] Ninth bit, error, data readable
// [R16] Clearing continuous enable clears error
// [R17] Software clears enables before new reception
// [R18] Software enables global, peripheral interrupts
// [R19] Half duplex: one direction at a time
// [R20] Clock idle level follows polarity bit
// [R21] Clock toggles only during active transfer
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module sync_master_serial_txrx
  import sync_serial_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             shift_clock_line,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  input  wire logic        serial_data_in,
  output logic             tx_irq,
  output logic             rx_irq
);

  typedef enum logic [1:0] {IDLE, TX_SHIFT, RX_SHIFT} mode_e;

  logic [7:0]  tx_ctrl_r;
  logic [7:0]  rx_ctrl_r;
  logic [7:0]  rate_ctrl_r;
  logic [7:0]  div_high_r;
  logic [7:0]  div_low_r;
  logic [7:0]  holding_r;
  logic        holding_ninth_r;
  logic        holding_full_r;
  logic        tx_irq_en_r;
  logic        rx_irq_en_r;
  logic        rx_flag_r;
  logic        overrun_r;
  logic [7:0]  rx_data_r;
  logic        rx_ninth_r;
  logic [8:0]  shifter_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] div_cnt_r;
  logic        phase_r;
  mode_e       mode_r;
  logic [SYNC_STAGES-1:0] din_sync_r;

  logic        wr_en;
  logic        rd_en;
  logic        port_on;
  logic        rx_want;
  logic        tick;
  logic [15:0] div_val;
  logic [3:0]  word_bits;
  logic        tx_load;
  logic        last_edge;
  logic        rx_done;
  logic        rx_read;

  assign wr_en   = psel && penable && pwrite && pready;
  assign rd_en   = psel && penable && !pwrite && pready;
  // Port active only with sync, master clock and port enable all set
  assign port_on = tx_ctrl_r[TXC_SYNC] && tx_ctrl_r[TXC_CLK_SRC] && rx_ctrl_r[RXC_PORT_EN];
  assign rx_want = port_on && (rx_ctrl_r[RXC_SINGLE] || rx_ctrl_r[RXC_CONT]); // [R10]
  assign div_val = rate_ctrl_r[RATE_WIDE] ? {div_high_r, div_low_r} : {8'h00, div_low_r};
  assign tick    = (div_cnt_r == div_val);

  always_comb begin
    if (mode_r == TX_SHIFT) begin
      word_bits = tx_ctrl_r[TXC_NINE] ? 4'd9 : 4'd8; // [R7]
    end else begin
      word_bits = rx_ctrl_r[RXC_NINE] ? 4'd9 : 4'd8;
    end
  end

  // Shifter may reload only from idle, i.e. after last bit left [R1]
  assign tx_load   = (mode_r == IDLE) && port_on && tx_ctrl_r[TXC_EN] && holding_full_r; // [R8]
  assign last_edge = tick && phase_r && (bit_cnt_r == word_bits - 4'd1);
  assign rx_done   = (mode_r == RX_SHIFT) && last_edge;
  assign rx_read   = rd_en && (paddr == RX_DATA_OFS);

  // APB access, zero wait states
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        // Shifter empty status is live; shifter itself has no address [R4] [R5]
        TX_CTRL_OFS:   prdata <= {24'h0, tx_ctrl_r[7:2], (mode_r != TX_SHIFT), tx_ctrl_r[0]};
        TX_BUF_OFS:    prdata <= {24'h0, holding_r};
        RX_CTRL_OFS:   prdata <= {24'h0, rx_ctrl_r[7:4], 2'b00, overrun_r, rx_ninth_r}; // [R15]
        RX_DATA_OFS:   prdata <= {24'h0, rx_data_r}; // [R15]
        RATE_CTRL_OFS: prdata <= {24'h0, rate_ctrl_r};
        DIV_HIGH_OFS:  prdata <= {24'h0, div_high_r};
        DIV_LOW_OFS:   prdata <= {24'h0, div_low_r};
        IRQ_OFS:       prdata <= {28'h0, rx_irq_en_r, tx_irq_en_r, rx_flag_r, !holding_full_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Transmit control register; the shifter empty bit is read live
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl_r <= TX_CTRL_RST;
    end else if (wr_en && paddr == TX_CTRL_OFS) begin
      tx_ctrl_r <= pwdata[7:0];
    end
  end

  // Receive control; single receive ends after one word unless continuous is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_r <= RX_CTRL_RST;
    end else if (wr_en && paddr == RX_CTRL_OFS) begin
      rx_ctrl_r <= pwdata[7:0];
    end else if (rx_done && !rx_ctrl_r[RXC_CONT]) begin
      rx_ctrl_r[RXC_SINGLE] <= 1'b0; // [R12] [R13]
    end
  end

  // Rate control: clock polarity and divisor width
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ctrl_r <= RATE_CTRL_RST;
    end else if (wr_en && paddr == RATE_CTRL_OFS) begin
      rate_ctrl_r <= pwdata[7:0];
    end
  end

  // Divisor high byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_high_r <= DIV_RST;
    end else if (wr_en && paddr == DIV_HIGH_OFS) begin
      div_high_r <= pwdata[7:0];
    end
  end

  // Divisor low byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_low_r <= DIV_RST;
    end else if (wr_en && paddr == DIV_LOW_OFS) begin
      div_low_r <= pwdata[7:0];
    end
  end

  // Interrupt enables; the flag bits of this register are read-only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_en_r <= 1'b0;
      rx_irq_en_r <= 1'b0;
    end else if (wr_en && paddr == IRQ_OFS) begin
      tx_irq_en_r <= pwdata[IRQ_TX_EN];
      rx_irq_en_r <= pwdata[IRQ_RX_EN];
    end
  end

  // Holding buffer; empty flag is just !holding_full_r and only a write fills it [R3]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holding_r       <= 8'h00;
      holding_ninth_r <= 1'b0;
      holding_full_r  <= 1'b0;
    end else if (wr_en && paddr == TX_BUF_OFS) begin
      holding_r       <= pwdata[7:0];
      holding_ninth_r <= tx_ctrl_r[TXC_NINTH]; // [R7]
      holding_full_r  <= 1'b1; // [R3]
    end else if (tx_load) begin
      holding_full_r  <= 1'b0; // [R2]
    end
  end

  // Shift engine: half duplex, transmit has priority when idle [R19]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r    <= IDLE;
      shifter_r <= 9'h000;
      bit_cnt_r <= 4'd0;
      div_cnt_r <= 16'h0000;
      phase_r   <= 1'b0;
    end else begin
      case (mode_r)
        IDLE: begin
          div_cnt_r <= 16'h0000;
          phase_r   <= 1'b0;
          bit_cnt_r <= 4'd0;
          if (tx_load) begin
            shifter_r <= {holding_ninth_r, holding_r}; // [R2]
            mode_r    <= TX_SHIFT; // [R19]
          end else if (rx_want) begin
            mode_r    <= RX_SHIFT; // [R19]
          end
        end
        TX_SHIFT, RX_SHIFT: begin
          if (!port_on || (mode_r == RX_SHIFT && !rx_want)) begin
            mode_r <= IDLE;
          end else if (tick) begin
            div_cnt_r <= 16'h0000;
            phase_r   <= !phase_r;
            if (phase_r) begin
              if (mode_r == TX_SHIFT) begin
                shifter_r <= {1'b0, shifter_r[8:1]};
              end
              if (bit_cnt_r == word_bits - 4'd1) begin
                mode_r <= IDLE; // [R1]
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'd1;
              end
            end else if (mode_r == RX_SHIFT) begin
              // Trailing edge of the active clock (falling with the polarity bit clear): sample the line [R11]
              shifter_r <= {din_sync_r[SYNC_STAGES-1], shifter_r[8:1]};
            end
          end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
          end
        end
        default: mode_r <= IDLE;
      endcase
    end
  end

  // Input synchroniser for the data line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_sync_r <= '0;
    end else begin
      din_sync_r <= {din_sync_r[SYNC_STAGES-2:0], serial_data_in};
    end
  end

  // Received word; an overrun keeps the older word in place
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_r  <= 8'h00;
      rx_ninth_r <= 1'b0;
    end else if (rx_done && !(rx_flag_r && !rx_read)) begin
      if (rx_ctrl_r[RXC_NINE]) begin
        // Nine bits fill the whole shifter, ninth bit on top
        rx_data_r  <= shifter_r[7:0]; // [R15]
        rx_ninth_r <= shifter_r[8]; // [R15]
      end else begin
        rx_data_r  <= shifter_r[8:1]; // [R15]
        rx_ninth_r <= 1'b0;
      end
    end
  end

  // Receive complete flag; a completing word wins over a data read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_flag_r <= 1'b0;
    end else if (rx_done) begin
      rx_flag_r <= 1'b1; // [R14]
    end else if (rx_read) begin
      rx_flag_r <= 1'b0;
    end
  end

  // Overrun error: word done while flag still set; cleared with continuous enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_r <= 1'b0;
    end else if (rx_done && rx_flag_r && !rx_read) begin
      overrun_r <= 1'b1; // [R15]
    end else if (!rx_ctrl_r[RXC_CONT]) begin
      overrun_r <= 1'b0; // [R16]
    end
  end

  // Shift clock pin, idle level from the polarity bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_clock_line <= 1'b0;
    end else if (mode_r == IDLE) begin
      shift_clock_line <= rate_ctrl_r[RATE_POL]; // [R20] [R21]
    end else begin
      shift_clock_line <= rate_ctrl_r[RATE_POL] ^ !phase_r; // [R21]
    end
  end

  // Data pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= shifter_r[0];
    end
  end

  // Data pin drive enable, only while transmitting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_oe <= 1'b0;
    end else begin
      serial_data_oe <= (mode_r == TX_SHIFT); // [R19]
    end
  end

  // Transmit interrupt line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_irq_en_r && !holding_full_r; // [R3]
    end
  end

  // Receive interrupt line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rx_irq_en_r && rx_flag_r; // [R14]
    end
  end

endmodule : sync_master_serial_txrx

// ### sync_serial_chk_sva.sv
// Assertions on the bus and serial pins of the synchronous serial port
`timescale 1ns/10ps
module sync_serial_chk
  import sync_serial_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shift_clock_line,
  input wire logic        serial_data_out,
  input wire logic        serial_data_oe,
  input wire logic        serial_data_in,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic irq_wr;
  assign irq_wr = psel && penable && pwrite && paddr == IRQ_OFS;
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_no_error: assert property (pready |-> !pslverr)
    else $error("error response seen");
  chk_flag_sticky: assert property (irq_wr && pwdata[IRQ_TX_EN] && tx_irq |=> tx_irq [*2])
    else $error("transmit flag cleared by software");
  chk_rx_masked: assert property (irq_wr && !pwdata[IRQ_RX_EN] |=> ##1 !rx_irq)
    else $error("receive interrupt while disabled");
  chk_rx_read_clear: assert property (psel && penable && !pwrite && paddr == RX_DATA_OFS
    |=> ##1 !rx_irq)
    else $error("receive flag kept after data read");
  chk_clk_half: assert property ($changed(shift_clock_line) |=> $stable(shift_clock_line))
    else $error("shift clock half period too short");
  chk_frame_len: assert property ($rose(serial_data_oe) |=> serial_data_oe [*8])
    else $error("transmit frame cut short");
  cover property ($rose(serial_data_oe));
  cover property ($rose(rx_irq));
  cover property (irq_wr && tx_irq);
endmodule : sync_serial_chk
bind sync_master_serial_txrx sync_serial_chk chk_i (.ref_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .shift_clock_line, .serial_data_out,
  .serial_data_oe, .serial_data_in, .tx_irq, .rx_irq);

// ### sync_peer_model.sv
// Behavioural peripheral that shifts words in and out on the shift clock
`timescale 1ns/10ps
module sync_peer_model (
  input  wire logic       shift_clock_line,
  input  wire logic       serial_data_out,
  input  wire logic       serial_data_oe,
  input  wire logic       pol,
  input  wire logic       nine,
  input  wire logic [7:0] rx_byte,
  output logic            serial_data_in,
  output logic            word_done,
  output logic      [8:0] word
);
  logic [8:0] cap;
  int         n;
  int         ri;
  realtime    last;
  initial begin
    serial_data_in = 1'b0;
    word_done = 1'b0;
    word = 9'h000;
    cap = 9'h000;
    n = 0;
    ri = 0;
    last = 0;
  end
  always @(shift_clock_line) begin
    #1;
    if ($realtime - last > 200.0) begin
      ri = 0;
      n = 0;
    end
    last = $realtime;
    if (shift_clock_line === pol) begin
      if (!serial_data_oe) begin
        ri = (ri == 7) ? 0 : ri + 1;
      end
    end else if (serial_data_oe) begin
      cap = {serial_data_out, cap[8:1]};
      n++;
      if (n == (nine ? 9 : 8)) begin
        word = nine ? cap : {1'b0, cap[8:1]};
        n = 0;
        word_done = 1'b1;
        #1 word_done = 1'b0;
      end
    end else begin
      serial_data_in = rx_byte[ri];
    end
  end
endmodule : sync_peer_model

// ### sync_master_serial_txrx_bench.sv
// Self-checking bench for the synchronous master serial port
`timescale 1ns/10ps
module sync_master_serial_txrx_bench;
  import sync_serial_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, serial_data_in, pol, nine;
  logic        pready, pslverr, shift_clock_line, serial_data_out, serial_data_oe;
  logic        tx_irq, rx_irq, word_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rs;
  logic [7:0]  rx_byte, d;
  logic [8:0]  word;
  logic [63:0] nt;
  logic [63:0] note_q[$];
  logic [8:0]  tx_q[$];
  int          err_count, num_checks, cyc;
  sync_master_serial_txrx dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .shift_clock_line, .serial_data_out, .serial_data_oe,
    .serial_data_in, .tx_irq, .rx_irq);
  sync_peer_model peer (.shift_clock_line, .serial_data_out, .serial_data_oe, .pol, .nine,
    .rx_byte, .serial_data_in, .word_done, .word);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [31:0] m);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w) note_q.push_back({m, v});
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wait_on(input logic [11:0] a, input int b);
    repeat (4) @(posedge ref_clk);
    do bus(1'b0, a, 32'h0, 32'h0); while (q[b] !== 1'b1);
  endtask : wait_on
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && note_q.size() > 0) begin
      nt = note_q.pop_front();
      if (nt[63:32] != 32'h0) chk(prdata & nt[63:32], nt[31:0] & nt[63:32]);
    end
  end
  always @(posedge word_done) begin
    chk({23'h0, word}, tx_q.size() > 0 ? {23'h0, tx_q.pop_front()} : 32'hffffffff);
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pol = 1'b0;
    nine = 1'b0;
    rx_byte = 8'h00;
    rs = 32'd66;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, TX_CTRL_OFS, {24'h0, TX_CTRL_RST}, 32'hff);
    bus(1'b0, RX_CTRL_OFS, 32'h0, 32'hff);
    bus(1'b0, 12'h020, 32'h0, 32'hffffffff);
    bus(1'b1, TX_CTRL_OFS, 32'h0, 32'h0);
    bus(1'b0, TX_CTRL_OFS, 32'h2, 32'h2);
    // Half period of eight cycles: 160 ns link clock, room for the input synchroniser
    bus(1'b1, DIV_LOW_OFS, 32'h7, 32'h0);
    bus(1'b1, RX_CTRL_OFS, 32'h80, 32'h0);
    for (int p = 1; p >= 0; p--) begin
      pol <= p[0];
      nine <= p[0];
      bus(1'b1, RATE_CTRL_OFS, 32'(p) << RATE_POL, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, shift_clock_line}, 32'(p));
      bus(1'b1, TX_CTRL_OFS, p[0] ? 32'hf1 : 32'hb0, 32'h0);
      repeat (2) begin
        d = rnd();
        tx_q.push_back({p[0], d});
        bus(1'b1, TX_BUF_OFS, {24'h0, d}, 32'h0);
      end
      while (tx_q.size() > 0) @(posedge ref_clk);
      wait_on(TX_CTRL_OFS, TXC_EMPTY);
    end
    bus(1'b1, IRQ_OFS, 32'h4, 32'h0);
    bus(1'b0, IRQ_OFS, 32'h5, 32'hf);
    chk({31'h0, tx_irq}, 32'h1);
    bus(1'b1, IRQ_OFS, 32'h4, 32'h0);
    rx_byte <= rnd();
    bus(1'b1, IRQ_OFS, 32'h8, 32'h0);
    bus(1'b1, RX_CTRL_OFS, 32'hb0, 32'h0);
    wait_on(RX_CTRL_OFS, RXC_OVERRUN);
    chk({31'h0, rx_irq}, 32'h1);
    bus(1'b0, RX_DATA_OFS, {24'h0, rx_byte}, 32'hff);
    bus(1'b1, RX_CTRL_OFS, 32'h80, 32'h0);
    bus(1'b0, RX_CTRL_OFS, 32'h80, 32'hff);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, RX_DATA_OFS, 32'h0, 32'h0);
    rx_byte <= rnd();
    bus(1'b1, RX_CTRL_OFS, 32'ha0, 32'h0);
    wait_on(IRQ_OFS, IRQ_RX_FLAG);
    bus(1'b0, RX_DATA_OFS, {24'h0, rx_byte}, 32'hff);
    repeat (100) @(posedge ref_clk);
    bus(1'b0, RX_CTRL_OFS, 32'h80, 32'hff);
    bus(1'b0, IRQ_OFS, 32'h9, 32'hf);
    final_report();
  end
endmodule : sync_master_serial_txrx_bench
